/* File: async_tx_map.svh */
// register offsets, field positions and codes of the transmit descriptor engine
`ifndef ASYNC_TX_MAP_SVH
`define ASYNC_TX_MAP_SVH
`define CTL_OFFSET      8'h00
`define PTR_OFFSET      8'h04
`define IRQ_CNT_OFFSET  8'h08
`define CTL_RUN         15
`define CTL_WAKE        12
`define CTL_DEAD        11
`define CTL_ACTIVE      10
`define CTL_RESPONSE    8
`define CMD_LAST        4'h1
`define KEY_BUFFER      3'h0
`define KEY_INLINE      3'h2
`define ICTL_ALWAYS     2'b11
`define ICTL_ON_ERROR   2'b01
`define EVT_ACK_DONE    5'h11
`define EVT_ACK_PEND    5'h12
`define EVT_NO_ACK      5'h03
`define STATUS_OFFSET   32'h0000_000c
`define BRANCH_OFFSET   32'h0000_0008
`define BLOCK_WORDS     5'h1f
`endif

/* File: async_tx_pkg.sv */
// types shared by the transmit descriptor engine
`default_nettype none
package async_tx_pkg;
  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_FETCH   = 4'b0001,
    S_LOAD    = 4'b0010,
    S_DECODE  = 4'b0011,
    S_BUF_RD  = 4'b0100,
    S_PUSH    = 4'b0101,
    S_INLINE  = 4'b0110,
    S_ACK     = 4'b0111,
    S_WB      = 4'b1000,
    S_NEXT    = 4'b1001,
    S_CHAIN   = 4'b1010,
    S_WAKE    = 4'b1011,
    S_WAKE_RD = 4'b1100
  } state_t;
  typedef logic [31:0] quad_t;
endpackage
`default_nettype wire

/* File: block_mem_if.sv */
// carrier between the engine and its descriptor block store
`default_nettype none
interface block_mem_if;
  logic                  we;
  logic [4:0]            waddr;
  async_tx_pkg::quad_t   wdata;
  logic [4:0]            raddr;
  async_tx_pkg::quad_t   rdata;
  modport engine (output we, output waddr, output wdata, output raddr, input rdata);
  modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: desc_block_mem.sv */
// store for one prefetched descriptor block of up to eight 16-byte blocks
`default_nettype none
module desc_block_mem
  import async_tx_pkg::*;
(
  input wire logic    aclk,
  block_mem_if.store  port
);
  quad_t mem [0:31];
  // ==========================================
  // write port and registered read port
  always_ff @(posedge aclk)
  begin
    if (port.we)
    begin
      mem[port.waddr] <= port.wdata;
    end
    port.rdata <= mem[port.raddr];
  end
endmodule // desc_block_mem
`default_nettype wire

/* File: completion_judge.sv */
// decides whether a finished packet raises an interrupt
`include "async_tx_map.svh"
`default_nettype none
module completion_judge (
  input  wire logic [1:0] int_ctl,
  input  wire logic [4:0] event_code,
  output logic            raise
);
  // ==========================================
  // interrupt-control decode
  always_comb
  begin
    case (int_ctl)
      `ICTL_ALWAYS:   raise = 1'b1;
      `ICTL_ON_ERROR: raise = (event_code != `EVT_ACK_DONE) && (event_code != `EVT_ACK_PEND);
      default:        raise = 1'b0;
    endcase
  end
endmodule // completion_judge
`default_nettype wire

/* File: async_tx_final.sv */
// asynchronous transmit engine for packet-ending descriptors
// Overview of operation
// - irq per interrupt-control: always, on error, never
// - buffer descriptor moves exactly request_byte_count bytes
// - next pointer gets four zero low bits
// - next-block count sizes fetch, zero ends
// - inline descriptor counts as two blocks
// - status enable writes control bits 15:0
// - status enable clear leaves descriptor untouched
// - stamp is three second bits, cycle index
// - request packets get ack-time stamp written
// - response packets leave stamp field alone
// - inline descriptor pushes one to four quadlets
// - inline type is command 1, key 2
// - inline descriptor spans 32 bytes, header after
// - final descriptor marks end of packet
// - buffer type is command 1, key 0
// - stamp taken at ack or timeout, one write
// - zero count ends program, wake resumes
`include "async_tx_map.svh"
`default_nettype none
module async_tx_final (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             hm_rd_req,
  output logic             hm_wr_req,
  output logic [31:0]      hm_addr,
  output logic [31:0]      hm_wdata,
  output logic [3:0]       hm_wstrb,
  input  wire logic        hm_rd_valid,
  input  wire logic [31:0] hm_rd_data,
  input  wire logic        hm_wr_done,
  output logic             tx_valid,
  output logic [31:0]      tx_data,
  output logic [3:0]       tx_keep,
  output logic             tx_last,
  input  wire logic        tx_ready,
  input  wire logic        ack_valid,
  input  wire logic [4:0]  ack_code,
  input  wire logic        ack_timeout,
  input  wire logic [2:0]  second_count_low,
  input  wire logic [12:0] cycle_index,
  output logic             irq
);
  import async_tx_pkg::*;

  state_t      state_reg;
  logic        run_reg, wake_reg, dead_reg, active_reg, resp_reg;
  logic [4:0]  evt_reg;
  logic [31:0] ptr_reg, irq_cnt_reg;
  logic [27:0] base_reg;
  logic [3:0]  z_reg, blk_reg, lc_reg;
  logic [5:0]  fcnt_reg;
  logic [1:0]  qi_reg;
  quad_t       q0_reg, q1_reg, q2_reg, buf_word_reg;
  quad_t       hdr_reg [0:3];
  logic [15:0] rem_reg, stamp_reg;
  logic [4:0]  rd_ptr_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  aw_addr_reg;
  quad_t       w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_exec, rd_take, slot_free, push, push_last, raise, wake_taken;
  logic [31:0] desc_addr;
  logic [15:0] ctl_word;
  quad_t       push_data;
  logic [3:0]  push_keep;

  block_mem_if bm ();
  desc_block_mem u_mem (
    .aclk (aclk),
    .port (bm)
  );
  completion_judge u_judge (
    .int_ctl    (q0_reg[21:20]),
    .event_code (evt_reg),
    .raise      (raise)
  );

  // ==========================================
  // register bus slave
  assign wr_exec = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign ctl_word = {run_reg, 2'b00, wake_reg, dead_reg, active_reg, 1'b0, resp_reg,
                     3'b000, evt_reg};

  // write address and data held until both are present
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_exec)
      begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_exec)
      begin
        w_hold_reg <= 1'b0;
      end
      s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
      if (wr_exec)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == `CTL_OFFSET || aw_addr_reg == `PTR_OFFSET ||
                         aw_addr_reg == `IRQ_CNT_OFFSET) ? 2'b00 : 2'b11;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `CTL_OFFSET:     s_axi_rdata <= {16'h0000, ctl_word};
          `PTR_OFFSET:     s_axi_rdata <= ptr_reg;
          `IRQ_CNT_OFFSET: s_axi_rdata <= irq_cnt_reg;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b11;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // channel control and command pointer
  assign wake_taken = (state_reg == S_WAKE) && wake_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_reg    <= 1'b0;
      wake_reg   <= 1'b0;
      resp_reg   <= 1'b0;
      ptr_reg    <= 32'h0000_0000;
      active_reg <= 1'b0;
      dead_reg   <= 1'b0;
      evt_reg    <= 5'h00;
    end
    else
    begin
      if (wr_exec && aw_addr_reg == `CTL_OFFSET && w_strb_reg[1])
      begin
        run_reg  <= w_data_reg[`CTL_RUN];
        resp_reg <= w_data_reg[`CTL_RESPONSE];
      end
      // a wake written in the cycle it is consumed stays set
      if (wr_exec && aw_addr_reg == `CTL_OFFSET && w_strb_reg[1] && w_data_reg[`CTL_WAKE])
      begin
        wake_reg <= 1'b1;
      end
      else if (wake_taken)
      begin
        wake_reg <= 1'b0;
      end
      if (wr_exec && aw_addr_reg == `PTR_OFFSET)
      begin
        ptr_reg <= w_data_reg;
      end
      active_reg <= (state_reg != S_IDLE) && (state_reg != S_WAKE);
      if (state_reg == S_IDLE && run_reg && ptr_reg[3:0] != 4'h0)
      begin
        dead_reg <= 1'b0;
      end
      else if (state_reg == S_DECODE && q0_reg[31:28] != `CMD_LAST &&
               blk_reg + ((q0_reg[26:24] == `KEY_INLINE) ? 4'h2 : 4'h1) >= z_reg)
      begin
        dead_reg <= 1'b1;
      end
      if (state_reg == S_ACK && ack_valid)
      begin
        evt_reg <= ack_code;
      end
      else if (state_reg == S_ACK && ack_timeout)
      begin
        evt_reg <= `EVT_NO_ACK;
      end
    end
  end

  // ==========================================
  // transmit FIFO stream
  assign slot_free = !tx_valid || tx_ready;
  assign push = slot_free && (state_reg == S_PUSH || state_reg == S_INLINE);
  assign push_data = (state_reg == S_INLINE) ? hdr_reg[qi_reg] : buf_word_reg;
  assign push_last = (state_reg == S_INLINE) ? ({1'b0, qi_reg} + 3'd1 == q0_reg[4:2])
                                             : (rem_reg <= 16'h0004);
  always_comb
  begin
    if (state_reg == S_INLINE || rem_reg >= 16'h0004)
      push_keep = 4'hf;
    else
    begin
      case (rem_reg[1:0])
        2'b11:   push_keep = 4'h7;
        2'b10:   push_keep = 4'h3;
        2'b01:   push_keep = 4'h1;
        default: push_keep = 4'h0;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_valid <= 1'b0;
      tx_data  <= 32'h0000_0000;
      tx_keep  <= 4'h0;
      tx_last  <= 1'b0;
    end
    else if (push)
    begin
      tx_valid <= 1'b1;
      tx_data  <= push_data;
      tx_keep  <= push_keep;
      tx_last  <= push_last;
    end
    else if (tx_ready)
    begin
      tx_valid <= 1'b0;
    end
  end

  // ==========================================
  // descriptor store access
  assign desc_addr = {base_reg + {24'h00_0000, blk_reg}, 4'h0};
  assign bm.we    = (state_reg == S_FETCH) && hm_rd_valid;
  assign bm.waddr = fcnt_reg[4:0];
  assign bm.wdata = hm_rd_data;
  assign bm.raddr = rd_ptr_reg;

  // ==========================================
  // descriptor walk and host memory port
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= S_IDLE;
      hm_rd_req <= 1'b0;
      hm_wr_req <= 1'b0;
      hm_addr   <= 32'h0000_0000;
      hm_wdata  <= 32'h0000_0000;
      hm_wstrb  <= 4'h0;
      base_reg  <= 28'h000_0000;
      z_reg     <= 4'h0;
      blk_reg   <= 4'h0;
      lc_reg    <= 4'h0;
      fcnt_reg  <= 6'h00;
      qi_reg    <= 2'b00;
      rd_ptr_reg <= 5'h00;
      q0_reg    <= 32'h0000_0000;
      q1_reg    <= 32'h0000_0000;
      q2_reg    <= 32'h0000_0000;
      buf_word_reg <= 32'h0000_0000;
      rem_reg   <= 16'h0000;
      stamp_reg <= 16'h0000;
      for (int k = 0; k < 4; k++) hdr_reg[k] <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (run_reg && ptr_reg[3:0] != 4'h0)
          begin
            base_reg  <= ptr_reg[31:4];
            z_reg     <= ptr_reg[3:0];
            fcnt_reg  <= 6'h00;
            hm_addr   <= {ptr_reg[31:4], 4'h0};
            hm_rd_req <= 1'b1;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          if (hm_rd_valid)
          begin
            fcnt_reg <= fcnt_reg + 6'h01;
            hm_addr  <= hm_addr + 32'h0000_0004;
            if (fcnt_reg + 6'h01 == {z_reg, 2'b00})
            begin
              hm_rd_req <= 1'b0;
              blk_reg   <= 4'h0;
              lc_reg    <= 4'h0;
              state_reg <= S_LOAD;
            end
          end
        end
        S_LOAD:
        begin
          // words 0..2 and 4..7 of the block; the stored read lags two edges
          rd_ptr_reg <= ({blk_reg[2:0], 2'b00} + {1'b0, lc_reg}) & `BLOCK_WORDS;
          lc_reg <= lc_reg + 4'h1;
          case (lc_reg)
            4'h2: q0_reg <= bm.rdata;
            4'h3: q1_reg <= bm.rdata;
            4'h4: q2_reg <= bm.rdata;
            4'h6: hdr_reg[0] <= bm.rdata;
            4'h7: hdr_reg[1] <= bm.rdata;
            4'h8: hdr_reg[2] <= bm.rdata;
            4'h9: hdr_reg[3] <= bm.rdata;
            default: ;
          endcase
          if (lc_reg == 4'h9)
            state_reg <= S_DECODE;
        end
        S_DECODE:
        begin
          lc_reg <= 4'h0;
          if (q0_reg[31:28] == `CMD_LAST && q0_reg[26:24] == `KEY_BUFFER)
          begin
            rem_reg <= q0_reg[15:0];
            hm_addr <= q1_reg;
            if (q0_reg[15:0] == 16'h0000)
              state_reg <= S_PUSH;
            else
            begin
              hm_rd_req <= 1'b1;
              state_reg <= S_BUF_RD;
            end
          end
          else if (q0_reg[31:28] == `CMD_LAST && q0_reg[26:24] == `KEY_INLINE)
          begin
            qi_reg    <= 2'b00;
            state_reg <= S_INLINE;
          end
          else
          begin
            // leading descriptors of the block: inline ones span two blocks
            blk_reg <= blk_reg + ((q0_reg[26:24] == `KEY_INLINE) ? 4'h2 : 4'h1);
            if (blk_reg + ((q0_reg[26:24] == `KEY_INLINE) ? 4'h2 : 4'h1) >= z_reg)
              state_reg <= S_WAKE;
            else
              state_reg <= S_LOAD;
          end
        end
        S_BUF_RD:
        begin
          if (hm_rd_valid)
          begin
            hm_rd_req    <= 1'b0;
            buf_word_reg <= hm_rd_data;
            state_reg    <= S_PUSH;
          end
        end
        S_PUSH:
        begin
          if (slot_free)
          begin
            if (rem_reg <= 16'h0004)
              state_reg <= S_ACK;
            else
            begin
              rem_reg   <= rem_reg - 16'h0004;
              hm_addr   <= hm_addr + 32'h0000_0004;
              hm_rd_req <= 1'b1;
              state_reg <= S_BUF_RD;
            end
          end
        end
        S_INLINE:
        begin
          if (slot_free)
          begin
            qi_reg <= qi_reg + 2'b01;
            if (push_last)
              state_reg <= S_ACK;
          end
        end
        S_ACK:
        begin
          if (ack_valid || ack_timeout)
          begin
            stamp_reg <= {second_count_low, cycle_index};
            hm_addr   <= desc_addr + `STATUS_OFFSET;
            if (q0_reg[27])
              state_reg <= S_WB;
            else
              state_reg <= S_NEXT;
          end
        end
        S_WB:
        begin
          // status and stamp share one write, raised with its data already standing
          if (!hm_wr_req)
          begin
            hm_wdata  <= {ctl_word, stamp_reg};
            hm_wstrb  <= resp_reg ? 4'b1100 : 4'b1111;
            hm_wr_req <= 1'b1;
          end
          else if (hm_wr_done)
          begin
            hm_wr_req <= 1'b0;
            state_reg <= S_NEXT;
          end
        end
        S_NEXT:
          state_reg <= S_CHAIN;
        S_CHAIN:
        begin
          if (q2_reg[3:0] == 4'h0 || !run_reg)
            state_reg <= S_WAKE;
          else
          begin
            base_reg  <= q2_reg[31:4];
            z_reg     <= q2_reg[3:0];
            fcnt_reg  <= 6'h00;
            hm_addr   <= {q2_reg[31:4], 4'h0};
            hm_rd_req <= 1'b1;
            state_reg <= S_FETCH;
          end
        end
        S_WAKE:
        begin
          if (!run_reg)
            state_reg <= S_IDLE;
          else if (wake_reg && !dead_reg)
          begin
            // reread the branch word of the last descriptor
            hm_addr   <= desc_addr + `BRANCH_OFFSET;
            hm_rd_req <= 1'b1;
            state_reg <= S_WAKE_RD;
          end
        end
        S_WAKE_RD:
        begin
          if (hm_rd_valid)
          begin
            hm_rd_req <= 1'b0;
            q2_reg    <= hm_rd_data;
            state_reg <= S_CHAIN;
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // completion interrupt and its count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq         <= 1'b0;
      irq_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      irq <= (state_reg == S_NEXT) && raise;
      if (state_reg == S_NEXT && raise)
        irq_cnt_reg <= irq_cnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_irq_always: assert property (state_reg == S_NEXT && q0_reg[21:20] == 2'b11 |=> irq)
    else $error("always-interrupt descriptor gave no irq");
  a_irq_never: assert property (state_reg == S_NEXT && q0_reg[21:20] == 2'b00 |=> !irq)
    else $error("never-interrupt descriptor gave irq");
  a_fetch_aligned: assert property ($rose(hm_rd_req) && state_reg == S_FETCH |-> hm_addr[3:0] == 4'h0)
    else $error("descriptor fetch not 16-byte aligned");
  a_wb_gated: assert property ($rose(hm_wr_req) |-> q0_reg[27])
    else $error("write-back with status disabled");
  a_status_word: assert property (hm_wr_req && hm_wr_done |-> hm_wdata[31:16] == ctl_word)
    else $error("status field differs from control word");
  a_stamp_value: assert property (state_reg == S_ACK && (ack_valid || ack_timeout)
    |=> stamp_reg == {$past(second_count_low), $past(cycle_index)})
    else $error("time stamp not taken at ack");
  a_resp_strobe: assert property (hm_wr_req && hm_wr_done && resp_reg |-> hm_wstrb == 4'b1100)
    else $error("response write touches the stamp");
  a_inline_end: assert property (state_reg == S_INLINE && push && push_last
    |=> tx_valid && tx_last && state_reg == S_ACK)
    else $error("inline packet not closed");
  a_fetch_first: assert property (state_reg == S_FETCH |-> !tx_valid || tx_last)
    else $error("bytes moved during fetch");
endmodule // async_tx_final
`default_nettype wire

/* File: host_mem.sv */
// host memory model holding descriptor lists and packet buffers
`default_nettype none
module host_mem (
  input  wire logic        aclk,
  input  wire logic        hm_rd_req,
  input  wire logic        hm_wr_req,
  input  wire logic [31:0] hm_addr,
  input  wire logic [31:0] hm_wdata,
  input  wire logic [3:0]  hm_wstrb,
  output logic             hm_rd_valid,
  output logic [31:0]      hm_rd_data,
  output logic             hm_wr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // storage and answer pacing
  logic [31:0] m [0:255];
  logic [1:0]  lag  = 2'h0;
  logic        slow = 1'b0;
  initial
  begin
    hm_rd_valid = 1'b0;
    hm_wr_done  = 1'b0;
    hm_rd_data  = 32'h0000_0000;
  end
  // one request at a time, replies alternate prompt and slow
  always @(posedge aclk)
  begin
    hm_rd_valid <= 1'b0;
    hm_wr_done  <= 1'b0;
    hm_rd_data  <= ~hm_rd_data; // no stale word between answers
    if ((hm_rd_req || hm_wr_req) && !hm_rd_valid && !hm_wr_done)
    begin
      if (lag == {slow, 1'b1})
      begin
        lag         <= 2'h0;
        slow        <= ~slow;
        hm_rd_valid <= hm_rd_req;
        hm_wr_done  <= hm_wr_req;
        if (hm_rd_req) hm_rd_data <= m[hm_addr[9:2]];
        for (int b = 0; b < 4; b++)
          if (hm_wr_req && hm_wstrb[b]) m[hm_addr[9:2]][8*b +: 8] <= hm_wdata[8*b +: 8];
      end
      else
        lag <= lag + 2'h1;
    end
  end
endmodule // host_mem
`default_nettype wire

/* File: async_tx_final_test.sv */
// self-checking bench for the packet-ending transmit engine
`default_nettype none
module async_tx_final_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus signals and bookkeeping
  typedef struct {logic [2:0] key; logic [1:0] ic; logic s; logic [15:0] nb;
                  logic [4:0] ack; logic irq;} row_t;
  logic        aclk = 0, aresetn = 0, tx_ready = 0, ack_valid = 0, ack_timeout = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [4:0]  ack_code = 0;
  logic [2:0]  second_count_low = 0;
  logic [12:0] cycle_index = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, hm_addr, hm_wdata, hm_rd_data, tx_data;
  logic [3:0]  hm_wstrb, tx_keep;
  logic        hm_rd_req, hm_wr_req, hm_rd_valid, hm_wr_done, tx_valid, tx_last, irq;
  int          err_total = 0, check_count = 0, irq_seen = 0;
  // ack of 0 stands for an ack timeout
  row_t rows [6] = '{'{3'h0, 2'b11, 1, 8, 5'h11, 1}, '{3'h0, 2'b01, 1, 6, 5'h11, 0},
                     '{3'h0, 2'b01, 1, 5, 5'h00, 1}, '{3'h2, 2'b00, 0, 8, 5'h03, 0},
                     '{3'h2, 2'b01, 1, 12, 5'h12, 0}, '{3'h2, 2'b01, 1, 16, 5'h14, 1}};
  async_tx_final i_dut (.*);
  host_mem       mem (.*);
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  // count interrupt pulses
  always @(posedge aclk) if (irq === 1'b1) irq_seen <= irq_seen + 1;
  function automatic logic [31:0] dat(input int k, input int j);
    return 32'hc0de_0000 + 32'(k * 256 + j);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, 0);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
  endtask
  // watchdog against a hung engine
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test();
  end
  // ==========================================================
  // descriptor list, one packet per row, then awkward cases
  initial
  begin
    int k, j, nbt, irq0, irq_exp;
    logic [31:0] f;
    irq_exp = 0;
    for (k = 0; k < 6; k++)
    begin
      f = 32'h40 * (k + 1) + (rows[k].key == 3'h2 ? 0 : 32);
      mem.m[(k + 1) * 16] = 32'h0200_0008; // leading two-block inline descriptor; overwritten for inline rows
      mem.m[f / 4] = {4'h1, rows[k].s, rows[k].key, 2'b00, rows[k].ic, 2'b11, 2'b00,
                      rows[k].nb};
      mem.m[f / 4 + 1] = 32'h300 + 16 * k;
      mem.m[f / 4 + 2] = k < 5 ? 32'h40 * (k + 2) + (rows[k + 1].key == 3'h2 ? 2 : 3)
                               : 32'hdead_bee0;
      mem.m[f / 4 + 3] = 32'h5a5a_5a5a;
      for (j = 0; j < 4; j++) mem.m[f / 4 + 4 + j] = dat(k, j);
      for (j = 0; j < 4; j++) mem.m[32'hc0 + 4 * k + j] = dat(k, j);
    end
    repeat (12) @(posedge aclk);
    chk({tx_valid, irq, hm_rd_req, hm_wr_req, s_axi_bvalid}, 0);
    aresetn <= 1'b1;
    axi_rd(8'h10, 0, 2'b11);
    axi_wr(8'h04, 32'h0000_0043);
    axi_wr(8'h00, 32'h0000_8000);
    for (k = 0; k < 6; k++)
    begin
      f = 32'h40 * (k + 1) + (rows[k].key == 3'h2 ? 0 : 32);
      if (k == 5) axi_wr(8'h00, 32'h0000_8100);
      second_count_low <= 3'(k + 1);
      cycle_index <= 13'(13'h1f3c - k);
      nbt = (rows[k].nb + 3) / 4;
      for (j = 0; j < nbt; j++)
      begin
        do
        begin
          @(posedge aclk);
          tx_ready <= ~tx_ready;
        end
        while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
        chk(tx_data, dat(k, j));
        chk(tx_keep, (j == nbt - 1 && rows[k].nb % 4) ? 4'hf >> (4 - rows[k].nb % 4) : 4'hf);
        chk(tx_last, j == nbt - 1);
      end
      tx_ready <= 1'b0;
      irq0 = irq_seen;
      repeat (3) @(posedge aclk);
      ack_valid   <= rows[k].ack != 0;
      ack_timeout <= rows[k].ack == 0;
      ack_code    <= rows[k].ack;
      @(posedge aclk);
      ack_valid   <= 1'b0;
      ack_timeout <= 1'b0;
      repeat (30) @(posedge aclk);
      irq_exp += rows[k].irq;
      chk(irq_seen - irq0, rows[k].irq);
      chk(rows[k].s ? mem.m[f / 4 + 3] & 32'h8000_ffff : mem.m[f / 4 + 3],
          rows[k].s ? {16'h8000, ((k == 5) ? 16'h5a5a : {3'(k + 1), 13'(13'h1f3c - k)})}
                    : 32'h5a5a_5a5a);
    end
    chk(hm_rd_req, 0);
    axi_wr(8'h00, 32'h0000_9000);
    repeat (20) @(posedge aclk);
    axi_rd(8'h00, 32'h0000_8014, 0);
    axi_rd(8'h08, irq_exp, 0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({tx_valid, irq, hm_rd_req, hm_wr_req}, 0);
    aresetn <= 1'b1;
    axi_rd(8'h00, 0, 0);
    finish_test();
  end
endmodule // async_tx_final_test
`default_nettype wire
